// ### design/srsl_pkg.sv
// Constants, field layouts and carrier types of the service request status logic
package srsl_pkg;

  localparam int SRSL_W = 8;
  localparam int SRSL_NUM_BYTES = 3;

  // Index of each status byte in the byte array
  localparam int SRSL_IDX_PRI = 0;
  localparam int SRSL_IDX_EXT1 = 1;
  localparam int SRSL_IDX_EXT2 = 2;

  // Primary status byte fields
  localparam int SRSL_PRI_KEY = 0;
  localparam int SRSL_PRI_EXT = 2;
  localparam int SRSL_PRI_SWEEP = 4;
  localparam int SRSL_PRI_SYNTAX = 5;
  localparam int SRSL_PRI_RQS = 6;

  // First extended status byte fields
  localparam int SRSL_EXT1_SELFTEST = 0;
  localparam int SRSL_EXT1_POWER = 5;
  localparam int SRSL_EXT1_RFUNLVL = 6;
  localparam int SRSL_EXT1_AIRFLOW = 7;

  // Second extended status byte field
  localparam int SRSL_EXT2_PARAM = 0;

  // Bits that exist in each stored byte; all others read zero
  localparam logic [7:0] SRSL_PRI_USED = 8'h35;
  localparam logic [7:0] SRSL_EXT1_USED = 8'hE1;
  localparam logic [7:0] SRSL_EXT2_USED = 8'h01;

  // Reset values
  localparam logic [7:0] SRSL_STATUS_RST = 8'h00;
  localparam logic [7:0] SRSL_PMASK_RST = 8'h00;
  localparam logic [7:0] SRSL_EMASK_RST = 8'hFF;

  // Condition events, one-cycle pulses from the instrument
  typedef struct packed {
    logic key_press;
    logic end_sweep;
    logic syntax_err;
    logic self_test_fail;
    logic power_fail;
    logic rf_unlevel;
    logic airflow_fail;
    logic param_default;
  } srsl_events_s;

  // Decoded commands from the interface parser, one-cycle pulses
  typedef struct packed {
    logic primary_mask_cmd;
    logic ext1_mask_cmd;
    logic ext2_mask_cmd;
    logic status_clear_cmd;
    logic status_dump_cmd;
    logic device_clear;
    logic serial_poll;
    logic [7:0] data;
  } srsl_cmd_s;

  // Status dump sequencer
  typedef enum logic [3:0] {
    SRSL_DUMP_IDLE = 4'b0001,
    SRSL_DUMP_B1 = 4'b0010,
    SRSL_DUMP_B2 = 4'b0100,
    SRSL_DUMP_B3 = 4'b1000
  } srsl_dump_e;

endpackage

// ### design/srsl_status_byte.sv
// One sticky status byte with per-bit set and whole-byte clear
`timescale 1ns/1ps
module srsl_status_byte
  import srsl_pkg::*;
#(
  parameter logic [7:0] USED = 8'hFF
)(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] set_i,
  input wire logic clr_i,
  output logic [7:0] value_o
);

  logic [7:0] value_r;
  logic [7:0] value_nxt;

  // Set wins over a clear in the same cycle; unused bits never set
  always_comb
  begin
    value_nxt = (value_r & ~{8{clr_i}}) | (set_i & USED);
  end

  // Register
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      value_r <= SRSL_STATUS_RST;
    else
      value_r <= value_nxt;
  end

  assign value_o = value_r;

  a_unused_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (value_r & ~USED) == 8'h00) else $error("unused status bit set");

  a_set_wins: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (clr_i && ((set_i & USED) != 8'h00)) |=> ((value_r & $past(set_i & USED)) == $past(set_i & USED)))
    else $error("status event lost on clear");

endmodule

// ### design/srsl_top.sv
// Service request status logic: three status bytes, request masks, poll and dump
`timescale 1ns/1ps
// Notes on behaviour
// - Three eight-bit status bytes, each bit one condition.
// - Primary: key 0, extended change 2, sweep end 4, syntax 5, request 6.
// - First extended: self test 0, power 5, RF unleveled 6, airflow 7.
// - Second extended: bit 0 only, parameter forced to default.
// - Front-panel keys set bit 0 even in local control.
// - Request only when a set bit is enabled in its mask.
// - Primary mask is one binary byte after the primary mask command.
// - Primary mask resets to all zeros.
// - Extended masks gate into primary bit 2, itself gated by primary mask.
// - Both extended masks reset to all ones.
// - Masks restored only by power on or device clear.
// - Polled byte carries request service in bit 6.
// - Syntax and power errors appear in the status bytes.
// - Serial poll returns the primary byte and clears it.
// - Dump command sends all three bytes, one after another.
// - Status clear command clears every status byte.
module srsl_top
  import srsl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire srsl_events_s events_i,
  input wire srsl_cmd_s cmd_i,
  output logic srq_o,
  output logic [7:0] poll_byte_o,
  output logic poll_valid_o,
  output logic [7:0] dump_byte_o,
  output logic dump_valid_o
);

  logic [7:0] set_v [SRSL_NUM_BYTES];
  logic clr_v [SRSL_NUM_BYTES];
  logic [7:0] stat_v [SRSL_NUM_BYTES];
  logic [7:0] pmask_r, pmask_nxt;
  logic [7:0] e1mask_r, e1mask_nxt;
  logic [7:0] e2mask_r, e2mask_nxt;
  logic pwr_seen_r, pwr_seen_nxt;
  logic srq_r, srq_nxt;
  logic [7:0] poll_byte_r, poll_byte_nxt;
  logic poll_valid_r, poll_valid_nxt;
  logic [7:0] dump_byte_r, dump_byte_nxt;
  logic dump_valid_r, dump_valid_nxt;
  srsl_dump_e dump_st_r, dump_st_nxt;
  logic [7:0] rqs_bit;

  assign rqs_bit = 8'h01 << SRSL_PRI_RQS;

  // Event mapping into each byte
  always_comb
  begin
    set_v[SRSL_IDX_EXT1] = 8'h00;
    set_v[SRSL_IDX_EXT1][SRSL_EXT1_SELFTEST] = events_i.self_test_fail;
    set_v[SRSL_IDX_EXT1][SRSL_EXT1_POWER] = events_i.power_fail | !pwr_seen_r;
    set_v[SRSL_IDX_EXT1][SRSL_EXT1_RFUNLVL] = events_i.rf_unlevel;
    set_v[SRSL_IDX_EXT1][SRSL_EXT1_AIRFLOW] = events_i.airflow_fail;
    set_v[SRSL_IDX_EXT2] = 8'h00;
    set_v[SRSL_IDX_EXT2][SRSL_EXT2_PARAM] = events_i.param_default;
    set_v[SRSL_IDX_PRI] = 8'h00;
    set_v[SRSL_IDX_PRI][SRSL_PRI_KEY] = events_i.key_press;
    set_v[SRSL_IDX_PRI][SRSL_PRI_SWEEP] = events_i.end_sweep;
    set_v[SRSL_IDX_PRI][SRSL_PRI_SYNTAX] = events_i.syntax_err;
    set_v[SRSL_IDX_PRI][SRSL_PRI_EXT] = |(set_v[SRSL_IDX_EXT1] & e1mask_r)
                                        | |(set_v[SRSL_IDX_EXT2] & e2mask_r);
    clr_v[SRSL_IDX_PRI] = cmd_i.status_clear_cmd | cmd_i.serial_poll;
    clr_v[SRSL_IDX_EXT1] = cmd_i.status_clear_cmd;
    clr_v[SRSL_IDX_EXT2] = cmd_i.status_clear_cmd;
  end

  // The three status bytes
  generate
    for (genvar g = 0; g < SRSL_NUM_BYTES; g++)
    begin : g_byte
      localparam logic [7:0] USED_G = (g == SRSL_IDX_PRI) ? SRSL_PRI_USED :
                                      (g == SRSL_IDX_EXT1) ? SRSL_EXT1_USED : SRSL_EXT2_USED;
      srsl_status_byte #(
        .USED(USED_G)
      ) u_byte (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .set_i(set_v[g]),
        .clr_i(clr_v[g]),
        .value_o(stat_v[g])
      );
    end
  endgenerate

  // Masks, request line and poll answer
  always_comb
  begin
    pmask_nxt = pmask_r;
    e1mask_nxt = e1mask_r;
    e2mask_nxt = e2mask_r;
    if (cmd_i.device_clear)
    begin
      pmask_nxt = SRSL_PMASK_RST;
      e1mask_nxt = SRSL_EMASK_RST;
      e2mask_nxt = SRSL_EMASK_RST;
    end
    else
    begin
      if (cmd_i.primary_mask_cmd)
        pmask_nxt = cmd_i.data;
      if (cmd_i.ext1_mask_cmd)
        e1mask_nxt = cmd_i.data;
      if (cmd_i.ext2_mask_cmd)
        e2mask_nxt = cmd_i.data;
    end
    pwr_seen_nxt = 1'b1;
    srq_nxt = |(stat_v[SRSL_IDX_PRI] & pmask_r & SRSL_PRI_USED);
    poll_valid_nxt = cmd_i.serial_poll;
    poll_byte_nxt = poll_byte_r;
    if (cmd_i.serial_poll)
      poll_byte_nxt = stat_v[SRSL_IDX_PRI] | (srq_r ? rqs_bit : 8'h00);
  end

  // Status dump sequencer
  always_comb
  begin
    dump_st_nxt = dump_st_r;
    dump_valid_nxt = 1'b0;
    dump_byte_nxt = dump_byte_r;
    case (dump_st_r)
      SRSL_DUMP_IDLE:
        if (cmd_i.status_dump_cmd)
          dump_st_nxt = SRSL_DUMP_B1;
      SRSL_DUMP_B1:
      begin
        dump_byte_nxt = stat_v[SRSL_IDX_PRI] | (srq_r ? rqs_bit : 8'h00);
        dump_valid_nxt = 1'b1;
        dump_st_nxt = SRSL_DUMP_B2;
      end
      SRSL_DUMP_B2:
      begin
        dump_byte_nxt = stat_v[SRSL_IDX_EXT1];
        dump_valid_nxt = 1'b1;
        dump_st_nxt = SRSL_DUMP_B3;
      end
      SRSL_DUMP_B3:
      begin
        dump_byte_nxt = stat_v[SRSL_IDX_EXT2];
        dump_valid_nxt = 1'b1;
        dump_st_nxt = SRSL_DUMP_IDLE;
      end
      default:
        dump_st_nxt = SRSL_DUMP_IDLE;
    endcase
  end

  // Registers; reset is power on
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      pmask_r <= SRSL_PMASK_RST;
      e1mask_r <= SRSL_EMASK_RST;
      e2mask_r <= SRSL_EMASK_RST;
      pwr_seen_r <= 1'b0;
      srq_r <= 1'b0;
      poll_byte_r <= SRSL_STATUS_RST;
      poll_valid_r <= 1'b0;
      dump_byte_r <= SRSL_STATUS_RST;
      dump_valid_r <= 1'b0;
      dump_st_r <= SRSL_DUMP_IDLE;
    end
    else
    begin
      pmask_r <= pmask_nxt;
      e1mask_r <= e1mask_nxt;
      e2mask_r <= e2mask_nxt;
      pwr_seen_r <= pwr_seen_nxt;
      srq_r <= srq_nxt;
      poll_byte_r <= poll_byte_nxt;
      poll_valid_r <= poll_valid_nxt;
      dump_byte_r <= dump_byte_nxt;
      dump_valid_r <= dump_valid_nxt;
      dump_st_r <= dump_st_nxt;
    end
  end

  assign srq_o = srq_r;
  assign poll_byte_o = poll_byte_r;
  assign poll_valid_o = poll_valid_r;
  assign dump_byte_o = dump_byte_r;
  assign dump_valid_o = dump_valid_r;

  a_srq_gated: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ##1 srq_o == $past(|(stat_v[SRSL_IDX_PRI] & pmask_r))) else $error("request not gated by mask");

  a_mask_restore: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_i.device_clear |=> (pmask_r == SRSL_PMASK_RST) && (e1mask_r == SRSL_EMASK_RST)
                           && (e2mask_r == SRSL_EMASK_RST)) else $error("masks not restored");

  a_pmask_load: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (cmd_i.primary_mask_cmd && !cmd_i.device_clear) |=> pmask_r == $past(cmd_i.data))
    else $error("primary mask not loaded");

  a_poll_clears: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (cmd_i.serial_poll && set_v[SRSL_IDX_PRI] == 8'h00) |=> stat_v[SRSL_IDX_PRI] == 8'h00 ##1 !srq_o)
    else $error("poll did not clear primary byte");

  a_poll_rqs: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_i.serial_poll |=> poll_valid_o && (poll_byte_o[SRSL_PRI_RQS] == $past(srq_o)))
    else $error("poll byte request bit wrong");

  a_dump_three: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (cmd_i.status_dump_cmd && dump_st_r == SRSL_DUMP_IDLE) |=> !dump_valid_o ##1 dump_valid_o [*3] ##1 !dump_valid_o)
    else $error("dump sequence wrong");

  a_ext_to_pri: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (|(set_v[SRSL_IDX_EXT2] & e2mask_r)) |=> stat_v[SRSL_IDX_PRI][SRSL_PRI_EXT])
    else $error("extended change not flagged");

  a_key_sets: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    events_i.key_press |=> stat_v[SRSL_IDX_PRI][SRSL_PRI_KEY]) else $error("key press not recorded");

endmodule

// ### testbench/srsl_host_model.sv
// Bus controller model: issues decoded commands, collects poll and dump answers
`timescale 1ns/1ps
module srsl_host_model
  import srsl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [7:0] poll_byte_i,
  input wire logic poll_valid_i,
  input wire logic [7:0] dump_byte_i,
  input wire logic dump_valid_i,
  output srsl_cmd_s cmd_o
);
  initial cmd_o = '0;

  // Present one command for a single edge, then withdraw it
  task automatic issue(input srsl_cmd_s c);
    @(posedge ref_clk_i);
    cmd_o <= c;
    @(posedge ref_clk_i);
    cmd_o <= '0;
  endtask

  // Mask load: one binary byte with the selected mask commands
  task automatic mask(input logic [2:0] sel, input logic [7:0] v);
    srsl_cmd_s c;
    c = '0;
    c.primary_mask_cmd = sel[0];
    c.ext1_mask_cmd = sel[1];
    c.ext2_mask_cmd = sel[2];
    c.data = v;
    issue(c);
  endtask

  // Serial poll of this instrument, answer awaited a bounded time
  task automatic poll(output logic [7:0] b, output logic ok);
    srsl_cmd_s c;
    c = '0;
    c.serial_poll = 1'h1;
    issue(c);
    ok = 1'h0;
    b = '0;
    // The answer stands only in the cycle right after the poll edge, so look before waiting
    for (int i = 0; i < 4 && ok !== 1'h1; i++)
    begin
      #1;
      ok = poll_valid_i;
      b = poll_byte_i;
      @(posedge ref_clk_i);
    end
  endtask

  // Status dump: gather three bytes, first byte lands lowest
  task automatic dump(output logic [23:0] d, output int n);
    srsl_cmd_s c;
    c = '0;
    c.status_dump_cmd = 1'h1;
    issue(c);
    n = 0;
    d = '0;
    for (int i = 0; i < 8 && n < 3; i++)
    begin
      @(posedge ref_clk_i);
      #1;
      if (dump_valid_i === 1'h1)
      begin
        d = {dump_byte_i, d[23:8]};
        n++;
      end
    end
  endtask
endmodule

// ### testbench/tb_service_request_status_logic.sv
// Self-checking bench: random masks and events against poll, dump and request line
`timescale 1ns/1ps
module tb_service_request_status_logic;
  import srsl_pkg::*;
  logic ref_clk_i;
  logic reset_n_i;
  srsl_events_s events_i;
  srsl_cmd_s cmd;
  logic srq;
  logic poll_valid;
  logic dump_valid;
  logic [7:0] poll_byte;
  logic [7:0] dump_byte;
  logic [31:0] lfsr = 32'h2740;
  int miscompares = 0;
  int compares = 0;

  srsl_top i_srsl_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .events_i(events_i), .cmd_i(cmd),
    .srq_o(srq), .poll_byte_o(poll_byte), .poll_valid_o(poll_valid), .dump_byte_o(dump_byte),
    .dump_valid_o(dump_valid));
  srsl_host_model i_srsl_host_model (.ref_clk_i(ref_clk_i), .poll_byte_i(poll_byte),
    .poll_valid_i(poll_valid), .dump_byte_i(dump_byte), .dump_valid_i(dump_valid), .cmd_o(cmd));

  // Clock at 250 MHz
  initial
  begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected {ext2, ext1, primary} after events on cleared bytes
  function automatic logic [23:0] exp_bytes(input srsl_events_s e, input logic [7:0] m1, input logic [7:0] m2);
    logic [7:0] x1;
    logic [7:0] x2;
    x1 = {e.airflow_fail, e.rf_unlevel, e.power_fail, 4'h0, e.self_test_fail};
    x2 = {7'h00, e.param_default};
    return {x2, x1, 2'h0, e.syntax_err, e.end_sweep, 1'h0, |{x1 & m1, x2 & m2}, 1'h0, e.key_press};
  endfunction

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  // Pulse events for one edge
  task automatic ev(input srsl_events_s e);
    @(posedge ref_clk_i);
    events_i <= e;
    @(posedge ref_clk_i);
    events_i <= '0;
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #60000;
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    srsl_cmd_s c;
    srsl_events_s e;
    logic [23:0] d;
    logic [23:0] x;
    logic [7:0] b;
    logic [7:0] m0;
    logic [7:0] m1;
    logic [7:0] m2;
    logic ok;
    logic s;
    int n;
    reset_n_i = 1'h0;
    events_i = '0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    cmp_bit(srq, 1'h0, "srq after reset");
    i_srsl_host_model.dump(d, n);
    cmp_byte(8'(n), 8'h03, "dump count");
    cmp_byte(d[7:0], 8'h04, "power-on primary");
    cmp_byte(d[15:8], 8'h20, "power-on ext1");
    cmp_byte(d[23:16], 8'h00, "power-on ext2");
    i_srsl_host_model.poll(b, ok);
    cmp_byte(b, 8'h04, "first poll");
    i_srsl_host_model.poll(b, ok);
    cmp_byte(b, 8'h00, "second poll");
    // Masks changed, then device clear must restore all three
    i_srsl_host_model.mask(3'h1, 8'hFF);
    i_srsl_host_model.mask(3'h6, 8'h00);
    c = '0;
    c.device_clear = 1'h1;
    i_srsl_host_model.issue(c);
    ev(8'h90);
    repeat (2) @(posedge ref_clk_i);
    #1;
    cmp_bit(srq, 1'h0, "srq after device clear");
    i_srsl_host_model.dump(d, n);
    cmp_byte(d[7:0], 8'h05, "key and ext change");
    cmp_byte(d[15:8], 8'h21, "ext1 self test");
    // Single events with all masks open, then random masks and events
    for (int k = 0; k < 40; k++)
    begin
      lfsr = next_rand(lfsr);
      m0 = (k < 8) ? 8'hFF : lfsr[7:0];
      m1 = (k < 8) ? 8'hFF : lfsr[15:8];
      m2 = (k < 8) ? 8'hFF : lfsr[23:16];
      lfsr = next_rand(lfsr);
      e = (k < 8) ? srsl_events_s'(8'h80 >> k) : srsl_events_s'(lfsr[7:0]);
      i_srsl_host_model.mask(3'h1, m0);
      i_srsl_host_model.mask(3'h2, m1);
      i_srsl_host_model.mask(3'h4, m2);
      c = '0;
      c.status_clear_cmd = 1'h1;
      i_srsl_host_model.issue(c);
      ev(e);
      x = exp_bytes(e, m1, m2);
      s = |(x[7:0] & m0);
      repeat (2) @(posedge ref_clk_i);
      #1;
      cmp_bit(srq, s, "srq from masks");
      i_srsl_host_model.dump(d, n);
      cmp_byte(d[7:0], x[7:0] | {1'h0, s, 6'h00}, "dump primary");
      cmp_byte(d[15:8], x[15:8], "dump ext1");
      cmp_byte(d[23:16], x[23:16], "dump ext2");
      i_srsl_host_model.poll(b, ok);
      cmp_bit(ok, 1'h1, "poll answered");
      cmp_byte(b, x[7:0] | {1'h0, s, 6'h00}, "poll byte");
      @(posedge ref_clk_i);
      #1;
      cmp_bit(srq, 1'h0, "srq after poll");
    end
    // Power on again with the primary mask open: all masks must fall back to defaults
    i_srsl_host_model.mask(3'h1, 8'hFF);
    @(posedge ref_clk_i);
    reset_n_i <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    cmp_bit(srq, 1'h0, "srq after second reset");
    i_srsl_host_model.dump(d, n);
    cmp_byte(d[7:0], 8'h04, "second power-on primary");
    cmp_byte(d[15:8], 8'h20, "second power-on ext1");
    // Key press in the very cycle of a poll: the new event survives the clear
    fork
      ev(8'h80);
      i_srsl_host_model.poll(b, ok);
    join
    cmp_bit(ok, 1'h1, "poll with key answered");
    cmp_byte(b, 8'h04, "poll with key press");
    i_srsl_host_model.dump(d, n);
    cmp_byte(d[7:0], 8'h01, "key kept over poll clear");
    stop_test();
  end
endmodule
